// File: imp_pkg.sv
// package for the interrupt mask and priority-level register bank
// assumes a byte-addressed cpu data space with 20-bit addresses
package imp_pkg;

	// ==============================================================
	// register addresses
	localparam logic [19:0] ADDR_MASK_G0_LOW = 20'hfffe4;
	localparam logic [19:0] ADDR_MASK_G0_HIGH = 20'hfffe5;
	localparam logic [19:0] ADDR_MASK_G1_LOW = 20'hfffe6;
	localparam logic [19:0] ADDR_MASK_G1_HIGH = 20'hfffe7;
	localparam logic [19:0] ADDR_MASK_G2_LOW = 20'hfffd4;
	localparam logic [19:0] ADDR_MASK_G2_HIGH = 20'hfffd5;
	localparam logic [19:0] ADDR_MASK_G3_LOW = 20'hfffd6;
	localparam logic [19:0] ADDR_LV0_G0_LOW = 20'hfffe8;
	localparam logic [19:0] ADDR_LV0_G0_HIGH = 20'hfffe9;
	localparam logic [19:0] ADDR_LV0_G1_LOW = 20'hfffea;
	localparam logic [19:0] ADDR_LV0_G1_HIGH = 20'hfffeb;
	localparam logic [19:0] ADDR_LV0_G2_LOW = 20'hfffd8;
	localparam logic [19:0] ADDR_LV0_G2_HIGH = 20'hfffd9;
	localparam logic [19:0] ADDR_LV0_G3_LOW = 20'hfffda;
	localparam logic [19:0] ADDR_LV1_G0_LOW = 20'hfffec;
	localparam logic [19:0] ADDR_LV1_G0_HIGH = 20'hfffed;
	localparam logic [19:0] ADDR_LV1_G1_LOW = 20'hfffee;
	localparam logic [19:0] ADDR_LV1_G1_HIGH = 20'hfffef;
	localparam logic [19:0] ADDR_LV1_G2_LOW = 20'hfffdc;
	localparam logic [19:0] ADDR_LV1_G2_HIGH = 20'hfffdd;
	localparam logic [19:0] ADDR_LV1_G3_LOW = 20'hfffde;

	// ==============================================================
	// layout, reset values and timing
	localparam int NUM_BYTES = 7;
	localparam int NUM_SRC = 56;
	localparam logic [2:0] IDX_G3_LOW = 3'h6;
	localparam logic [7:0] RESET_BYTE = 8'hff;
	localparam logic [7:0] G3_FIXED_ONES = 8'hc0;
	localparam logic [1:0] WRITE_STRETCH = 2'h2;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==============================================================
	// register kinds and address decode result
	typedef enum logic [1:0] {IMP_KIND_MASK, IMP_KIND_LV0, IMP_KIND_LV1} imp_kind_t;

	typedef struct packed {
		logic hit;
		imp_kind_t kind;
		logic [2:0] idx;
	} imp_dec_t;

endpackage

// File: imp_arb_if.sv
// carrier between the register bank and its arbiter
// assumes both ends share one clock
`timescale 1ns/1ps
interface imp_arb_if #(parameter int N = 56);
	logic [N-1:0] req;
	logic [2*N-1:0] lvl;
	logic win_valid;
	logic [5:0] win_idx;
	logic [1:0] win_lvl;

	modport bank (output req, output lvl, input win_valid, input win_idx, input win_lvl);
	modport arb (input req, input lvl, output win_valid, output win_idx, output win_lvl);
endinterface

// File: imp_arbiter.sv
// selects the one unmasked request the cpu should acknowledge first
// assumes req and lvl come from flip-flops in the register bank
`timescale 1ns/1ps
module imp_arbiter
	import imp_pkg::*;
#(
	parameter int N = NUM_SRC
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// request and level side
	imp_arb_if.arb arb
);

	typedef struct packed {
		logic valid;
		logic [5:0] idx;
		logic [1:0] lvl;
	} imp_arb_state_t;

	imp_arb_state_t state_reg;
	imp_arb_state_t state_next;

	// ==============================================================
	// best level first, lowest index breaks a tie
	always_comb begin
		state_next = '0;
		state_next.lvl = 2'h3;
		for (int i = N - 1; i >= 0; i--) begin
			// walking downward with <= lets the lower index win ties
			if (arb.req[i] && (!state_next.valid || arb.lvl[2*i +: 2] <= state_next.lvl)) begin
				state_next.valid = 1'b1;
				state_next.idx = 6'(i);
				state_next.lvl = arb.lvl[2*i +: 2];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// idle winner shows index 0 at the lowest level
			state_reg <= '{valid: 1'b0, idx: 6'h0, lvl: 2'h3};
		end else begin
			state_reg <= state_next;
		end
	end

	assign arb.win_valid = state_reg.valid;
	assign arb.win_idx = state_reg.idx;
	assign arb.win_lvl = state_reg.lvl;

endmodule

// File: imp_bank.sv
// interrupt mask and two-bit priority-level register bank, top level
// assumes the cpu drives one access per cycle, holds it while cpu_wait
// is high, and that request flags arrive synchronous to clk
`timescale 1ns/1ps
module imp_bank
	import imp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// cpu data access
	input wire logic [19:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	input wire logic cpu_wr_byte,
	input wire logic cpu_wr_word,
	input wire logic cpu_wr_bit,
	input wire logic [2:0] cpu_bit_sel,
	input wire logic cpu_bit_val,
	input wire logic cpu_rd,
	input wire logic cpu_rd_word,
	output logic [15:0] cpu_rdata,
	output logic cpu_wait,
	// request flags from the flag registers
	input wire logic [NUM_SRC-1:0] irq_flag,
	// towards the acknowledge logic
	output logic [NUM_SRC-1:0] irq_masked_req,
	output logic [2*NUM_SRC-1:0] irq_level,
	output logic ack_valid,
	output logic [5:0] ack_index,
	output logic [1:0] ack_level
);

	// ==============================================================
	// state
	// byte index 0..6 = group 0 low, 0 high, 1 low, 1 high, 2 low, 2 high, 3 low;
	// source number = 8 * byte index + bit position
	typedef struct packed {
		logic [NUM_BYTES-1:0][7:0] mask;
		logic [NUM_BYTES-1:0][7:0] lv0;
		logic [NUM_BYTES-1:0][7:0] lv1;
		logic [NUM_SRC-1:0] masked;
		logic [15:0] rdata;
		logic [1:0] wait_cnt;
	} imp_state_t;

	imp_state_t state_reg;
	imp_state_t state_next;

	imp_arb_if #(.N(NUM_SRC)) arb_link ();

	// ==============================================================
	// address decode, shared by both byte lanes of reads and writes
	function automatic imp_dec_t imp_decode(input logic [19:0] a);
		imp_dec_t d;
		d.hit = 1'b1;
		d.kind = IMP_KIND_MASK;
		d.idx = 3'h0;
		case (a)
			ADDR_MASK_G0_LOW: d.idx = 3'h0;
			ADDR_MASK_G0_HIGH: d.idx = 3'h1;
			ADDR_MASK_G1_LOW: d.idx = 3'h2;
			ADDR_MASK_G1_HIGH: d.idx = 3'h3;
			ADDR_MASK_G2_LOW: d.idx = 3'h4;
			ADDR_MASK_G2_HIGH: d.idx = 3'h5;
			ADDR_MASK_G3_LOW: d.idx = 3'h6;
			ADDR_LV0_G0_LOW: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h0;
			end
			ADDR_LV0_G0_HIGH: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h1;
			end
			ADDR_LV0_G1_LOW: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h2;
			end
			ADDR_LV0_G1_HIGH: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h3;
			end
			ADDR_LV0_G2_LOW: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h4;
			end
			ADDR_LV0_G2_HIGH: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h5;
			end
			ADDR_LV0_G3_LOW: begin
				d.kind = IMP_KIND_LV0;
				d.idx = 3'h6;
			end
			ADDR_LV1_G0_LOW: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h0;
			end
			ADDR_LV1_G0_HIGH: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h1;
			end
			ADDR_LV1_G1_LOW: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h2;
			end
			ADDR_LV1_G1_HIGH: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h3;
			end
			ADDR_LV1_G2_LOW: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h4;
			end
			ADDR_LV1_G2_HIGH: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h5;
			end
			ADDR_LV1_G3_LOW: begin
				d.kind = IMP_KIND_LV1;
				d.idx = 3'h6;
			end
			default: d.hit = 1'b0;
		endcase
		return d;
	endfunction

	// ==============================================================
	// byte fetch from the current register image
	function automatic logic [7:0] imp_fetch(input imp_state_t s, input imp_dec_t d);
		logic [7:0] b;
		b = UNMAPPED_READ;
		if (d.hit) begin
			case (d.kind)
				IMP_KIND_MASK: b = s.mask[d.idx];
				IMP_KIND_LV0: b = s.lv0[d.idx];
				IMP_KIND_LV1: b = s.lv1[d.idx];
				default: b = UNMAPPED_READ;
			endcase
		end
		return b;
	endfunction

	// ==============================================================
	// next state
	logic wr_req;
	logic [1:0] lane_en;
	logic [1:0][19:0] lane_addr;
	logic [1:0][7:0] lane_wdata;

	// a write offered while stretching is held by the cpu, not taken
	assign wr_req = (cpu_wr_byte || cpu_wr_word || cpu_wr_bit) && (state_reg.wait_cnt == 2'h0);
	assign lane_addr[0] = cpu_addr;
	assign lane_addr[1] = cpu_addr + 20'h1;
	assign lane_wdata[0] = cpu_wdata[7:0];
	assign lane_wdata[1] = cpu_wdata[15:8];
	assign lane_en[0] = wr_req;
	// words only on even addresses; group 3 has no upper partner so lane 1 misses
	assign lane_en[1] = wr_req && cpu_wr_word && !cpu_addr[0];

	always_comb begin
		imp_dec_t d;
		logic [7:0] b;
		logic hit_any;
		d = '0;
		b = 8'h00;
		hit_any = 1'b0;
		state_next = state_reg;
		if (state_reg.wait_cnt != 2'h0) begin
			state_next.wait_cnt = state_reg.wait_cnt - 2'h1;
		end
		for (int lane = 0; lane < 2; lane++) begin
			d = imp_decode(lane_addr[lane]);
			if (lane_en[lane] && d.hit) begin
				hit_any = 1'b1;
				b = imp_fetch(state_reg, d);
				// bit write alters one bit, byte or word write replaces the byte
				if (cpu_wr_bit) begin
					b[cpu_bit_sel] = cpu_bit_val;
				end else begin
					b = lane_wdata[lane];
				end
				if (d.idx == IDX_G3_LOW) begin
					b = b | G3_FIXED_ONES;
				end
				case (d.kind)
					IMP_KIND_MASK: state_next.mask[d.idx] = b;
					IMP_KIND_LV0: state_next.lv0[d.idx] = b;
					IMP_KIND_LV1: state_next.lv1[d.idx] = b;
					default: state_next.mask[d.idx] = state_reg.mask[d.idx];
				endcase
			end
		end
		if (hit_any) begin
			state_next.wait_cnt = WRITE_STRETCH;
		end
		// read data lands one cycle after the strobe
		if (cpu_rd) begin
			state_next.rdata[7:0] = imp_fetch(state_reg, imp_decode(lane_addr[0]));
			state_next.rdata[15:8] = UNMAPPED_READ;
			if (cpu_rd_word && !cpu_addr[0]) begin
				state_next.rdata[15:8] = imp_fetch(state_reg, imp_decode(lane_addr[1]));
			end
		end
		// zero mask lets a raised flag through, one blocks it
		state_next.masked = irq_flag & ~state_reg.mask;
	end

	// ==============================================================
	// registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg.mask <= {NUM_BYTES{RESET_BYTE}};
			state_reg.lv0 <= {NUM_BYTES{RESET_BYTE}};
			state_reg.lv1 <= {NUM_BYTES{RESET_BYTE}};
			state_reg.masked <= '0;
			state_reg.rdata <= 16'h0000;
			state_reg.wait_cnt <= 2'h0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==============================================================
	// per-source level, bit1 above bit0: 0 is highest, 3 lowest
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_level
		assign irq_level[2*i +: 2] = {state_reg.lv1[i / 8][i % 8], state_reg.lv0[i / 8][i % 8]};
	end

	assign arb_link.req = state_reg.masked;
	assign arb_link.lvl = irq_level;

	imp_arbiter #(
		.N(NUM_SRC)
	) u_arbiter (
		.clk(clk),
		.reset(reset),
		.arb(arb_link.arb)
	);

	// ==============================================================
	// outputs
	assign cpu_rdata = state_reg.rdata;
	assign cpu_wait = (state_reg.wait_cnt != 2'h0);
	assign irq_masked_req = state_reg.masked;
	assign ack_valid = arb_link.win_valid;
	assign ack_index = arb_link.win_idx;
	assign ack_level = arb_link.win_lvl;

endmodule

// File: imp_monitor.sv
// checker for the mask and priority-level bank, port view only
// assumes it is bound to imp_bank and shares its clock and reset
`timescale 1ns/1ps
module imp_monitor
	import imp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// cpu access
	input wire logic [19:0] cpu_addr,
	input wire logic cpu_wr_byte,
	input wire logic cpu_wr_word,
	input wire logic cpu_rd,
	input wire logic [15:0] cpu_rdata,
	input wire logic cpu_wait,
	// request path
	input wire logic [NUM_SRC-1:0] irq_flag,
	input wire logic [NUM_SRC-1:0] irq_masked_req,
	input wire logic [2*NUM_SRC-1:0] irq_level,
	input wire logic ack_valid,
	input wire logic [5:0] ack_index,
	input wire logic [1:0] ack_level
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [NUM_SRC-1:0] req_d;
	logic [2*NUM_SRC-1:0] lvl_d;
	// ==========================================
	// delayed copies of what the winner was built from
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			req_d <= '0;
			lvl_d <= '1;
		end else begin
			req_d <= irq_masked_req;
			lvl_d <= irq_level;
		end
	end
	// ==========================================
	// register access
	property p_wait_two;
		(cpu_wr_byte || cpu_wr_word) && !cpu_wait && cpu_addr == ADDR_MASK_G1_LOW
			|=> cpu_wait [*2] ##1 !cpu_wait;
	endproperty
	a_wait_two: assert property (p_wait_two) else $error("write stretch wrong");
	property p_g3_mask; cpu_rd && cpu_addr == ADDR_MASK_G3_LOW |=> cpu_rdata[7:6] == 2'h3; endproperty
	a_g3_mask: assert property (p_g3_mask) else $error("g3 mask top bits");
	property p_g3_lvl;
		cpu_rd && (cpu_addr == ADDR_LV0_G3_LOW || cpu_addr == ADDR_LV1_G3_LOW) |=> cpu_rdata[7:6] == 2'h3;
	endproperty
	a_g3_lvl: assert property (p_g3_lvl) else $error("g3 level top bits");
	property p_reset_vals; $fell(reset) |-> &irq_level && irq_masked_req == '0 && !cpu_wait; endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset state");
	// ==========================================
	// request path
	property p_req_gated; 1'b1 |-> (irq_masked_req & ~$past(irq_flag)) == '0; endproperty
	a_req_gated: assert property (p_req_gated) else $error("request without flag");
	property p_ack_any; 1'b1 |-> ack_valid == (|req_d); endproperty
	a_ack_any: assert property (p_ack_any) else $error("ack valid wrong");
	property p_ack_src; ack_valid |-> req_d[ack_index]; endproperty
	a_ack_src: assert property (p_ack_src) else $error("winner not requesting");
	property p_ack_lvl; ack_valid |-> ack_level == lvl_d[2*ack_index +: 2]; endproperty
	a_ack_lvl: assert property (p_ack_lvl) else $error("winner level wrong");
	c_wait: cover property (cpu_wait ##1 cpu_wait);
	c_ack0: cover property (ack_valid && ack_level == 2'h0);
	c_word: cover property (cpu_wr_word && !cpu_wait);
endmodule

// File: imp_src_model.sv
// request flags and acknowledge side facing the bank
// assumes the bench raises flags by set_req and gates taking by ack_en
`timescale 1ns/1ps
module imp_src_model
	import imp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bench control
	input wire logic [NUM_SRC-1:0] set_req,
	input wire logic ack_en,
	input wire logic [1:0] ack_gap,
	// bank side
	input wire logic ack_valid,
	input wire logic [5:0] ack_index,
	output logic [NUM_SRC-1:0] irq_flag,
	output logic took,
	output logic [5:0] took_idx
);
	logic [2:0] hold;
	// hold spans the two-cycle winner pipeline, so a stale winner is never taken
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_flag <= '0;
			hold <= '0;
			took <= 1'b0;
			took_idx <= '0;
		end else begin
			took <= 1'b0;
			irq_flag <= irq_flag | set_req;
			if (hold != 3'h0) begin
				hold <= hold - 3'h1;
			end else if (ack_en && ack_valid) begin
				irq_flag[ack_index] <= 1'b0;
				hold <= 3'h2 + {1'b0, ack_gap};
				took <= 1'b1;
				took_idx <= ack_index;
			end
		end
	end
endmodule

// File: testbench.sv
// self-checking bench for the mask and priority-level bank
// assumes imp_bank, imp_src_model and imp_monitor are compiled before it
`timescale 1ns/1ps
module testbench
	import imp_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [19:0] cpu_addr = '0;
	logic [15:0] cpu_wdata = '0;
	logic cpu_wr_byte = 0, cpu_wr_word = 0, cpu_wr_bit = 0, cpu_rd = 0, cpu_rd_word = 0;
	logic [2:0] cpu_bit_sel = '0;
	logic cpu_bit_val = 0, ack_en = 0, cpu_wait, ack_valid, took;
	logic [15:0] cpu_rdata;
	logic [NUM_SRC-1:0] irq_flag, irq_masked_req, set_req = '0, flags = '0, pend, mvec;
	logic [2*NUM_SRC-1:0] irq_level;
	logic [5:0] ack_index, took_idx;
	logic [1:0] ack_level, ack_gap = '0;
	logic [7:0] m [21];
	logic [19:0] tab [21] = '{ADDR_MASK_G0_LOW, ADDR_MASK_G0_HIGH, ADDR_MASK_G1_LOW,
		ADDR_MASK_G1_HIGH, ADDR_MASK_G2_LOW, ADDR_MASK_G2_HIGH, ADDR_MASK_G3_LOW,
		ADDR_LV0_G0_LOW, ADDR_LV0_G0_HIGH, ADDR_LV0_G1_LOW, ADDR_LV0_G1_HIGH,
		ADDR_LV0_G2_LOW, ADDR_LV0_G2_HIGH, ADDR_LV0_G3_LOW, ADDR_LV1_G0_LOW, ADDR_LV1_G0_HIGH,
		ADDR_LV1_G1_LOW, ADDR_LV1_G1_HIGH, ADDR_LV1_G2_LOW, ADDR_LV1_G2_HIGH, ADDR_LV1_G3_LOW};
	int seed = 42, err_total = 0, compares = 0, i, j, best;
	always #4 clk = ~clk;
	imp_bank DUT (.clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr_byte(cpu_wr_byte), .cpu_wr_word(cpu_wr_word), .cpu_wr_bit(cpu_wr_bit),
		.cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd),
		.cpu_rd_word(cpu_rd_word), .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait),
		.irq_flag(irq_flag), .irq_masked_req(irq_masked_req), .irq_level(irq_level),
		.ack_valid(ack_valid), .ack_index(ack_index), .ack_level(ack_level));
	imp_src_model src (.clk(clk), .reset(reset), .set_req(set_req), .ack_en(ack_en),
		.ack_gap(ack_gap), .ack_valid(ack_valid), .ack_index(ack_index),
		.irq_flag(irq_flag), .took(took), .took_idx(took_idx));
	// ==========================================
	// reference model and bus tasks
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic int find(input logic [19:0] a);
		for (int k = 0; k < 21; k++) if (tab[k] == a) return k;
		return -1;
	endfunction
	function automatic logic [1:0] lv(input int n);
		return {m[14 + n / 8][n % 8], m[7 + n / 8][n % 8]};
	endfunction
	// kind 0 byte, 1 word, 2 bit with select in d[10:8] and value in d[0]
	task automatic wr(input logic [19:0] a, input logic [15:0] d, input int kind);
		int k;
		k = find(a);
		while (cpu_wait !== 1'b0) @(negedge clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_bit_sel = d[10:8];
		cpu_bit_val = d[0];
		cpu_wr_byte = kind == 0;
		cpu_wr_word = kind == 1;
		cpu_wr_bit = kind == 2;
		@(negedge clk);
		{cpu_wr_byte, cpu_wr_word, cpu_wr_bit} = 3'h0;
		if (k < 0) return;
		if (kind == 2) m[k][d[10:8]] = d[0];
		else m[k] = d[7:0];
		if (kind == 1 && k % 7 < 6 && !a[0]) m[k + 1] = d[15:8];
		// absent top bits of group 3 stay at their reset value of one
		if (k % 7 == 6) m[k] = m[k] | G3_FIXED_ONES;
	endtask
	task automatic rd(input logic [19:0] a, input logic wide);
		int k;
		logic [15:0] e;
		k = find(a);
		e = (k >= 0) ? {8'h00, m[k]} : 16'h0000;
		if (wide) e[15:8] = m[k + 1];
		cpu_addr = a;
		cpu_rd = 1'b1;
		cpu_rd_word = wide;
		@(negedge clk);
		cpu_rd = 1'b0;
		cpu_rd_word = 1'b0;
		chk(cpu_rdata, e, "rdata");
		// idle edge so a following read never re-raises the strobe in this step
		@(negedge clk);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		for (i = 0; i < 21; i++) m[i] = RESET_BYTE;
		for (i = 0; i < 21; i++) rd(tab[i], 1'b0);
		$display("test reset values done");
		wr(20'hfffe0, 16'h0000, 0);
		rd(20'hfffe0, 1'b0);
		for (i = 0; i < 21; i++) begin
			wr(tab[i], 16'($random(seed)), 0);
			rd(tab[i], 1'b0);
			wr(tab[i], 16'($random(seed)), 2);
			rd(tab[i], 1'b0);
		end
		$display("test byte and bit access done");
		for (i = 0; i < 21; i++) begin
			if (i % 7 < 6 && i % 7 % 2 == 0) begin
				wr(tab[i], 16'($random(seed)), 1);
				rd(tab[i], 1'b1);
			end
		end
		$display("test word access done");
		repeat (6) begin
			for (i = 0; i < 21; i++) wr(tab[i], 16'($random(seed)), 0);
			set_req = 56'({$random(seed), $random(seed)});
			flags = flags | set_req;
			@(negedge clk);
			set_req = '0;
			repeat (3) @(negedge clk);
			for (i = 0; i < NUM_SRC; i++) mvec[i] = m[i / 8][i % 8];
			pend = flags & ~mvec;
			chk(irq_masked_req, pend, "masked_req");
			ack_gap = 2'($random(seed));
			ack_en = 1'b1;
			while (pend != '0) begin
				best = -1;
				for (i = 0; i < NUM_SRC; i++)
					if (pend[i] && (best < 0 || lv(i) < lv(best))) best = i;
				j = 0;
				do begin
					@(negedge clk);
					j++;
				end while (took !== 1'b1 && j < 50);
				chk({took, took_idx}, {1'b1, 6'(best)}, "winner");
				chk(ack_level, lv(best), "level");
				pend[best] = 1'b0;
				flags[best] = 1'b0;
			end
			ack_en = 1'b0;
			repeat (4) @(negedge clk);
		end
		$display("test arbitration done");
		final_report();
	end
	initial begin
		#(8 * 20000);
		err_total++;
		final_report();
	end
endmodule
bind imp_bank imp_monitor mon (.clk(clk), .reset(reset), .cpu_addr(cpu_addr),
	.cpu_wr_byte(cpu_wr_byte), .cpu_wr_word(cpu_wr_word), .cpu_rd(cpu_rd),
	.cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait), .irq_flag(irq_flag), .irq_masked_req(irq_masked_req),
	.irq_level(irq_level), .ack_valid(ack_valid), .ack_index(ack_index), .ack_level(ack_level));
